// ---- verilog/cfg_pins_pkg.sv ----
// Purpose: Constants and carriers for the configuration control and test port pin block.
// Assumes: System clock 50 MHz; test clock is a separate domain.
// Notes: The test data registers are a one-bit bypass and a 32-bit identity register.
//
// What this block does
// RL1 - Done line is open drain: only pulled low or released, pull-up makes high.
// RL2 - Done line is released only after configuration has fully completed.
// RL3 - While done line is held low outside, the device stays out of user mode.
// RL4 - Host pulses reconfiguration request low; fresh configuration starts on its rising edge.
// RL5 - Reconfiguration request restarts configuration only; it never resets user logic.
// RL6 - Test port samples mode-select and serial input on rising test clock edges.
// RL7 - Test port serial output changes only after falling test clock edges.
// RL8 - Host should change mode-select and serial input after falling test clock edges.
// RL9 - Undriven mode-select or serial input is taken as logic one.
// RL10 - Serial data goes to instruction or selected data register; output from same register.
// RL11 - A shifted bit emerges after as many clocks as the selected register length.
// RL12 - Serial output is released to high impedance whenever no shifting happens.
// RL13 - Dedicated configuration pins keep their role and never become user I/O.
// RL14 - Dual-purpose configuration pins become user I/O once in user mode.
// RL15 - Multi-function pin without alternate function acts as ordinary user I/O.
// RL16 - Error output is pulled low on identity mismatch, check failure or update failure.
// RL17 - Mode strap is sampled at request rising edge: 0 passive, 1 active.
// RL18 - Configuration is accepted only while configuration chip select is high.
// RL19 - Test port controller follows the standard boundary-scan state machine.
package cfg_pins_pkg;

  // ----------------------------------------------------------------
  // Sizes and counts
  // ----------------------------------------------------------------
  localparam int IR_LEN = 4;
  localparam int ID_LEN = 32;
  localparam int DUAL_PINS = 4;
  localparam int MF_PINS = 4;
  localparam int SYNC_LEN = 3;
  localparam int CLK_PERIOD_NS = 20;
  localparam int CRESET_MIN_NS = 320;
  localparam int CRESET_MIN_CYC = (CRESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;

  // ----------------------------------------------------------------
  // Instructions and reset values
  // ----------------------------------------------------------------
  localparam logic [IR_LEN-1:0] IR_IDCODE = 4'h3;
  localparam logic [IR_LEN-1:0] IR_BYPASS = 4'hf;
  localparam logic [IR_LEN-1:0] IR_CAPTURE = 4'h1;
  // Arbitrary identity value with no meaning outside this design.
  localparam logic [ID_LEN-1:0] ID_VALUE = 32'h0000_0001;

  typedef enum logic {MODE_PASSIVE, MODE_ACTIVE} cfg_mode_t;

  typedef enum {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UP_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UP_IR
  } tap_state_t;

  typedef enum {CFG_IDLE, CFG_LOAD, CFG_DONE, CFG_ERR} cfg_state_t;

  typedef struct packed {
    logic tms;
    logic tdi;
  } tap_in_t;

  typedef struct packed {
    logic id_mismatch;
    logic check_fail;
    logic update_fail;
  } cfg_fault_t;

  typedef struct packed {
    logic [DUAL_PINS-1:0] o;
    logic [DUAL_PINS-1:0] oe_n;
  } dual_drive_t;

endpackage

// ---- verilog/tap_port.sv ----
`timescale 1ns/1ps
// Purpose: Boundary-scan test port running on the test clock.
// Assumes: Reset via the test reset state after five ones on mode-select.
// Notes: Output enable is active low.
module tap_port
  import cfg_pins_pkg::*;
(
  // Test clock domain
  input wire logic tck_i,
  input wire logic sys_reset_i,
  // Pins
  input wire tap_in_t tap_i,
  output logic tdo_o,
  output logic tdo_oe_n_o
);

  tap_state_t st_r;
  tap_state_t st_nxt;
  logic [IR_LEN-1:0] ir_sh_r;
  logic [IR_LEN-1:0] ir_r;
  logic [ID_LEN-1:0] id_r;
  logic byp_r;
  logic so_bit;
  logic [1:0] rst_s_r;

  // ----------------------------------------------------------------
  // Reset crossing
  // ----------------------------------------------------------------
  // Reset belongs to the system clock, so two stages bring it onto the test clock.
  // A short reset may be missed here; five ones on mode-select still reset the port.
  always_ff @(posedge tck_i) begin
    rst_s_r <= {rst_s_r[0], sys_reset_i};
  end

  // ----------------------------------------------------------------
  // Controller
  // ----------------------------------------------------------------
  always_comb begin
    case (st_r) // RL19
      TLR: st_nxt = tap_i.tms ? TLR : RTI;
      RTI: st_nxt = tap_i.tms ? SEL_DR : RTI;
      SEL_DR: st_nxt = tap_i.tms ? SEL_IR : CAP_DR;
      CAP_DR: st_nxt = tap_i.tms ? EX1_DR : SH_DR;
      SH_DR: st_nxt = tap_i.tms ? EX1_DR : SH_DR;
      EX1_DR: st_nxt = tap_i.tms ? UP_DR : PA_DR;
      PA_DR: st_nxt = tap_i.tms ? EX2_DR : PA_DR;
      EX2_DR: st_nxt = tap_i.tms ? UP_DR : SH_DR;
      UP_DR: st_nxt = tap_i.tms ? SEL_DR : RTI;
      SEL_IR: st_nxt = tap_i.tms ? TLR : CAP_IR;
      CAP_IR: st_nxt = tap_i.tms ? EX1_IR : SH_IR;
      SH_IR: st_nxt = tap_i.tms ? EX1_IR : SH_IR;
      EX1_IR: st_nxt = tap_i.tms ? UP_IR : PA_IR;
      PA_IR: st_nxt = tap_i.tms ? EX2_IR : PA_IR;
      EX2_IR: st_nxt = tap_i.tms ? UP_IR : SH_IR;
      UP_IR: st_nxt = tap_i.tms ? SEL_DR : RTI;
      default: st_nxt = TLR;
    endcase
  end

  // Sampling happens on the rising edge only.
  always_ff @(posedge tck_i) begin
    if (rst_s_r[1]) begin
      st_r <= TLR;
    end else begin
      st_r <= st_nxt; // RL6
    end
  end

  // ----------------------------------------------------------------
  // Shift paths
  // ----------------------------------------------------------------
  always_ff @(posedge tck_i) begin
    if (rst_s_r[1] || st_r == TLR) begin
      ir_r <= IR_IDCODE;
      ir_sh_r <= IR_CAPTURE;
    end else if (st_r == CAP_IR) begin
      ir_sh_r <= IR_CAPTURE;
    end else if (st_r == SH_IR) begin
      ir_sh_r <= {tap_i.tdi, ir_sh_r[IR_LEN-1:1]}; // RL10 RL11
    end else if (st_r == UP_IR) begin
      ir_r <= ir_sh_r;
    end
  end

  always_ff @(posedge tck_i) begin
    if (rst_s_r[1]) begin
      id_r <= ID_VALUE;
      byp_r <= 1'b0;
    end else if (st_r == CAP_DR) begin
      id_r <= ID_VALUE;
      byp_r <= 1'b0;
    end else if (st_r == SH_DR) begin
      if (ir_r == IR_IDCODE) begin
        id_r <= {tap_i.tdi, id_r[ID_LEN-1:1]}; // RL10 RL11
      end else begin
        byp_r <= tap_i.tdi; // RL11
      end
    end
  end

  always_comb begin
    if (st_r == SH_IR) begin
      so_bit = ir_sh_r[0]; // RL10
    end else if (ir_r == IR_IDCODE) begin
      so_bit = id_r[0];
    end else begin
      so_bit = byp_r;
    end
  end

  // ----------------------------------------------------------------
  // Output on the falling edge
  // ----------------------------------------------------------------
  // Launching on the falling edge gives the host half a period of hold margin.
  always_ff @(negedge tck_i) begin
    if (rst_s_r[1]) begin
      tdo_o <= 1'b0;
      tdo_oe_n_o <= 1'b1;
    end else begin
      tdo_o <= so_bit; // RL7
      tdo_oe_n_o <= !(st_r == SH_DR || st_r == SH_IR); // RL12
    end
  end

endmodule

// ---- verilog/cfg_pins.sv ----
`timescale 1ns/1ps
// Purpose: Configuration control pins, test port and dual-use pin steering.
// Assumes: Pins arrive asynchronously; the configuration engine reports through plain inputs.
// Notes: Undriven pins are modelled by the pull-up in the bench; inputs here see a level.
module cfg_pins
  import cfg_pins_pkg::*;
(
  // System
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // Reconfiguration request, strap, chip select
  input wire logic creset_n_i,
  input wire logic mode_strap_i,
  input wire logic chip_sel_i,
  // Configuration engine status
  input wire logic load_done_i,
  input wire cfg_fault_t fault_i,
  // Done line, open drain
  input wire logic config_done_flag_i,
  output logic config_done_flag_o,
  output logic config_done_flag_oe_n_o,
  // Error output, active low
  output logic config_error_n_o,
  // Status towards the configuration engine
  output logic cfg_start_o,
  output logic cfg_accept_o,
  output cfg_mode_t cfg_mode_o,
  output logic user_mode_o,
  // Test port
  input wire logic tck_i,
  input wire tap_in_t tap_i,
  output logic tdo_o,
  output logic tdo_oe_n_o,
  // Dual-purpose and multi-function pins
  input wire dual_drive_t user_dual_i,
  input wire dual_drive_t cfg_dual_i,
  output dual_drive_t dual_pin_o,
  input wire logic [MF_PINS-1:0] mf_alt_sel_i,
  input wire logic [MF_PINS-1:0] mf_alt_o_i,
  input wire logic [MF_PINS-1:0] mf_user_o_i,
  input wire logic [MF_PINS-1:0] mf_user_oe_n_i,
  output logic [MF_PINS-1:0] multi_function_pin_o,
  output logic [MF_PINS-1:0] multi_function_pin_oe_n_o
);

  cfg_state_t st_r;
  logic [SYNC_LEN-1:0] crst_s_r;
  logic [SYNC_LEN-1:0] done_s_r;
  logic [SYNC_LEN-1:0] cs_s_r;
  logic [SYNC_LEN-1:0] strap_s_r;
  logic crst_r;
  logic done_in_r;
  logic cs_r;
  logic [CNT_W-1:0] low_cnt_r;
  logic rise;
  logic user_nxt;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Stage 0 feeds only stage 1; a change counts when stages 1 and 2 agree, except on the strap, taken from stage 2.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      crst_s_r <= '1;
      done_s_r <= '0;
      cs_s_r <= '0;
      strap_s_r <= '0;
    end else begin
      crst_s_r <= {crst_s_r[1:0], creset_n_i};
      done_s_r <= {done_s_r[1:0], config_done_flag_i};
      cs_s_r <= {cs_s_r[1:0], chip_sel_i};
      strap_s_r <= {strap_s_r[1:0], mode_strap_i};
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      crst_r <= 1'b1;
      done_in_r <= 1'b0;
      cs_r <= 1'b0;
    end else begin
      if (crst_s_r[1] == crst_s_r[2]) begin
        crst_r <= crst_s_r[2];
      end
      if (done_s_r[1] == done_s_r[2]) begin
        done_in_r <= done_s_r[2];
      end
      if (cs_s_r[1] == cs_s_r[2]) begin
        cs_r <= cs_s_r[2];
      end
    end
  end

  assign rise = !crst_r && crst_s_r[1] && crst_s_r[2];

  // ----------------------------------------------------------------
  // Reconfiguration request
  // ----------------------------------------------------------------
  // A pulse shorter than the minimum starts no configuration; its rise still reloads cfg_mode_o from the strap.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || crst_r) begin
      low_cnt_r <= '0;
    end else if (low_cnt_r != CNT_W'(CRESET_MIN_CYC - 1)) begin
      low_cnt_r <= low_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      cfg_start_o <= 1'b0;
      cfg_mode_o <= MODE_PASSIVE;
    end else begin
      cfg_start_o <= rise && low_cnt_r == CNT_W'(CRESET_MIN_CYC - 1); // RL4
      if (rise) begin
        cfg_mode_o <= cfg_mode_t'(strap_s_r[2]); // RL17
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration state
  // ----------------------------------------------------------------
  // Only configuration state is cleared here; user pin logic keeps running.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      st_r <= CFG_IDLE;
    end else if (rise && low_cnt_r == CNT_W'(CRESET_MIN_CYC - 1)) begin
      st_r <= CFG_LOAD; // RL4 RL5
    end else begin
      case (st_r)
        CFG_IDLE: st_r <= CFG_IDLE;
        CFG_LOAD: begin
          if (|fault_i) begin
            st_r <= CFG_ERR;
          end else if (load_done_i && cs_r) begin
            st_r <= CFG_DONE; // RL18
          end
        end
        CFG_DONE: st_r <= CFG_DONE;
        CFG_ERR: st_r <= CFG_ERR;
        default: st_r <= CFG_IDLE;
      endcase
    end
  end

  assign user_nxt = st_r == CFG_DONE && done_in_r;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      config_done_flag_o <= 1'b0;
      config_done_flag_oe_n_o <= 1'b0;
      config_error_n_o <= 1'b1;
      cfg_accept_o <= 1'b0;
      user_mode_o <= 1'b0;
    end else begin
      config_done_flag_o <= 1'b0; // RL1
      config_done_flag_oe_n_o <= st_r == CFG_DONE; // RL1 RL2
      config_error_n_o <= st_r != CFG_ERR; // RL16
      cfg_accept_o <= st_r == CFG_LOAD && cs_r; // RL18
      user_mode_o <= user_nxt; // RL3
    end
  end

  // ----------------------------------------------------------------
  // Pin steering
  // ----------------------------------------------------------------
  // Dedicated pins (done, error, request, test port) have no user path at all.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      dual_pin_o <= '{o: '0, oe_n: '1};
    end else if (user_nxt) begin
      dual_pin_o <= user_dual_i; // RL14 RL13
    end else begin
      dual_pin_o <= cfg_dual_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      multi_function_pin_o <= '0;
      multi_function_pin_oe_n_o <= '1;
    end else begin
      for (int i = 0; i < MF_PINS; i++) begin
        multi_function_pin_o[i] <= mf_alt_sel_i[i] ? mf_alt_o_i[i] : mf_user_o_i[i]; // RL15
        multi_function_pin_oe_n_o[i] <= mf_alt_sel_i[i] ? 1'b0 : mf_user_oe_n_i[i]; // RL15
      end
    end
  end

  // ----------------------------------------------------------------
  // Test port
  // ----------------------------------------------------------------
  // Mode-select and data pins are pulled up on the board side, so an open pin reads one.
  tap_port u_tap (
    .tck_i(tck_i),
    .sys_reset_i(reset_i),
    .tap_i(tap_i), // RL9 RL8
    .tdo_o(tdo_o),
    .tdo_oe_n_o(tdo_oe_n_o)
  );

endmodule

// ---- dv/cfg_pins_chk.sv ----
// Purpose: Port checks for the configuration pin block.
// Assumes: Bound to every instance of the block.
// Notes: Windows allow for the three-stage pin synchronisers.
`timescale 1ns/1ps
module cfg_pins_chk
  import cfg_pins_pkg::*;
(
  // Watched inputs
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic creset_n_i,
  input wire logic mode_strap_i,
  input wire logic chip_sel_i,
  input wire logic load_done_i,
  input wire cfg_fault_t fault_i,
  input wire logic config_done_flag_i,
  input wire dual_drive_t user_dual_i,
  // Watched outputs
  input wire logic config_done_flag_o,
  input wire logic config_done_flag_oe_n_o,
  input wire logic config_error_n_o,
  input wire logic cfg_start_o,
  input wire logic cfg_accept_o,
  input wire cfg_mode_t cfg_mode_o,
  input wire logic user_mode_o,
  input wire dual_drive_t dual_pin_o
);
  // ----
  // Properties
  // ----
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  sequence s_pulse; cfg_start_o ##1 !cfg_start_o; endsequence
  sequence s_cs_off; !chip_sel_i [*6]; endsequence
  sequence s_wire_low; !config_done_flag_i [*6]; endsequence
  a_done_open_drain: assert property (config_done_flag_o == 1'b0)
    else $error("done line driven high");
  a_done_after_load: assert property ($rose(config_done_flag_oe_n_o) |->
    $past(load_done_i) || $past(load_done_i, 2)) else $error("done released early");
  a_wire_holds_off: assert property (s_wire_low |-> !user_mode_o)
    else $error("user mode while wire low");
  a_start_one_pulse: assert property (cfg_start_o |-> s_pulse) else $error("start too long");
  a_start_after_rise: assert property (cfg_start_o |->
    $past(creset_n_i, 3) && !$past(creset_n_i, 10)) else $error("start without pulse");
  a_start_user_off: assert property (cfg_start_o |-> ##[0:3] !user_mode_o)
    else $error("user mode kept on restart");
  a_mode_capture: assert property (cfg_start_o |-> ##[0:1] (cfg_mode_o == cfg_mode_t'(mode_strap_i)))
    else $error("mode not captured");
  a_accept_cs_off: assert property (s_cs_off |-> !cfg_accept_o) else $error("accept unselected");
  a_error_on_fault: assert property ($fell(config_error_n_o) |-> $past(fault_i) != 3'h0)
    else $error("error without fault");
  a_dual_user: assert property (user_mode_o && $past(user_mode_o) |-> dual_pin_o == $past(user_dual_i))
    else $error("dual pins not user");
endmodule
bind cfg_pins cfg_pins_chk cfg_pins_chk_i (.*);

// ---- dv/cfg_host.sv ----
// Purpose: Board host beside the block: pull-ups, done wire and test port driver.
// Assumes: Test clock runs only while a test frame is in progress.
// Notes: A step with the enable low leaves both test pins undriven.
`timescale 1ns/1ps
module cfg_host
  import cfg_pins_pkg::*;
(
  // Device side
  input wire logic done_o_i,
  input wire logic done_oe_n_i,
  input wire logic tdo_i,
  output logic done_wire_o,
  output logic tck_o,
  output tap_in_t tap_o
);
  logic hold_low = 1'b0;
  logic run = 1'b0;
  logic pin_en = 1'b0;
  logic tms_v = 1'b0;
  logic tdi_v = 1'b0;
  // ----
  // Wires and test clock
  // ----
  // The pull-up gives the high level; either side may pull low.
  assign done_wire_o = !((!done_oe_n_i && !done_o_i) || hold_low);
  assign tap_o = '{tms: pin_en ? tms_v : 1'b1, tdi: pin_en ? tdi_v : 1'b1};
  initial begin
    tck_o = 1'b0;
    forever begin
      #32;
      tck_o = run ? ~tck_o : 1'b0;
    end
  end
  // Pins move after the fall so they are steady at the rise.
  task automatic step(input logic en, input logic tms, input logic tdi, output logic tdo);
    @(negedge tck_o);
    pin_en <= en;
    tms_v <= tms;
    tdi_v <= tdi;
    @(posedge tck_o);
    tdo = tdo_i;
  endtask
endmodule

// ---- dv/cfg_pins_bench.sv ----
// Purpose: Self-checking bench for the configuration pin block.
// Assumes: Host model supplies pull-ups and the test clock.
// Notes: Multi-function select and alternate values stay fixed.
`timescale 1ns/1ps
module cfg_pins_bench;
  import cfg_pins_pkg::*;
  logic ref_clk_i = 1'b0, reset_i = 1'b1, creset_n_i = 1'b1, mode_strap_i = 1'b0;
  logic chip_sel_i = 1'b1, load_done_i = 1'b0;
  cfg_fault_t fault_i = '0;
  dual_drive_t user_dual_i = 8'h5a, cfg_dual_i = 8'ha5, dual_pin_o;
  logic [MF_PINS-1:0] mf_alt_sel_i = 4'h3, mf_alt_o_i = 4'hf, mf_user_o_i = 4'h5, mf_user_oe_n_i = 4'h0;
  logic [MF_PINS-1:0] multi_function_pin_o, multi_function_pin_oe_n_o;
  logic config_done_flag_i, config_done_flag_o, config_done_flag_oe_n_o, config_error_n_o;
  logic cfg_start_o, cfg_accept_o, user_mode_o, tck_i, tdo_o, tdo_oe_n_o;
  cfg_mode_t cfg_mode_o;
  tap_in_t tap_i;
  int num_errors = 0;
  int compares = 0;
  cfg_pins cfg_pins_i (.*);
  cfg_host cfg_host_i (.done_o_i(config_done_flag_o), .done_oe_n_i(config_done_flag_oe_n_o), .tdo_i(tdo_o),
    .done_wire_o(config_done_flag_i), .tck_o(tck_i), .tap_o(tap_i));
  // ----
  // Helpers
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic rcfg(input logic s, input int low, input logic exp);
    logic seen;
    seen = 1'b0;
    @(posedge ref_clk_i);
    creset_n_i <= 1'b0;
    mode_strap_i <= s;
    fault_i <= '0;
    repeat (low) @(posedge ref_clk_i);
    creset_n_i <= 1'b1;
    repeat (10) begin
      cyc(1);
      if (cfg_start_o === 1'b1) seen = 1'b1;
    end
    chk(seen, exp);
  endtask
  task automatic ld(input cfg_fault_t f);
    @(posedge ref_clk_i);
    fault_i <= f;
    load_done_i <= 1'b1;
    @(posedge ref_clk_i);
    load_done_i <= 1'b0;
    cyc(8);
  endtask
  task automatic walk(input logic [3:0] seq, input int n);
    logic b;
    for (int i = 0; i < n; i++) cfg_host_i.step(1'b1, seq[i], 1'b1, b);
  endtask
  task automatic shift(input int n, input logic [31:0] din, output logic [31:0] dout);
    logic b;
    dout = '0;
    for (int i = 0; i < n; i++) begin
      cfg_host_i.step(1'b1, i == n - 1, din[i], b);
      dout[i] = b;
    end
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_start();
    cyc(1);
    chk(config_done_flag_oe_n_o, 1'b0);
    chk(user_mode_o, 1'b0);
    rcfg(1'b0, 15, 1'b0);
    for (int s = 0; s < 2; s++) begin
      rcfg(s[0], 16, 1'b1);
      chk(cfg_mode_o, s);
    end
  endtask
  task automatic t_cs();
    @(posedge ref_clk_i);
    chip_sel_i <= 1'b0;
    cyc(6);
    chk(cfg_accept_o, 1'b0);
    ld('0);
    chk(config_done_flag_oe_n_o, 1'b0);
    @(posedge ref_clk_i);
    chip_sel_i <= 1'b1;
    cyc(6);
    chk(cfg_accept_o, 1'b1);
  endtask
  task automatic t_user();
    cfg_host_i.hold_low <= 1'b1;
    ld('0);
    chk(config_done_flag_oe_n_o, 1'b1);
    chk(user_mode_o, 1'b0);
    chk(dual_pin_o, cfg_dual_i);
    cfg_host_i.hold_low <= 1'b0;
    cyc(8);
    chk(user_mode_o, 1'b1);
    chk(dual_pin_o, user_dual_i);
    cfg_host_i.hold_low <= 1'b1;
    cyc(8);
    chk(user_mode_o, 1'b0);
    cfg_host_i.hold_low <= 1'b0;
    cyc(8);
    chk(user_mode_o, 1'b1);
    chk(multi_function_pin_o, 4'h7);
    chk(multi_function_pin_oe_n_o[3:2], 2'h0);
    @(posedge ref_clk_i);
    mf_user_o_i <= 4'ha;
    rcfg(1'b1, 20, 1'b1);
    chk(user_mode_o, 1'b0);
    chk(multi_function_pin_o, 4'hb);
  endtask
  task automatic t_fault();
    for (int k = 0; k < 3; k++) begin
      ld(cfg_fault_t'(3'h1 << k));
      chk(config_error_n_o, 1'b0);
      chk(config_done_flag_oe_n_o, 1'b0);
      rcfg(1'b0, 20, 1'b1);
      chk(config_error_n_o, 1'b1);
    end
  endtask
  task automatic t_tap();
    logic [31:0] got;
    logic b;
    cfg_host_i.run = 1'b1;
    repeat (5) cfg_host_i.step(1'b0, 1'b0, 1'b0, b);
    chk(tdo_oe_n_o, 1'b1);
    walk(4'h2, 4);
    shift(32, 32'h0, got);
    chk(got, ID_VALUE);
    chk(tdo_oe_n_o, 1'b0);
    walk(4'h1, 2);
    chk(tdo_oe_n_o, 1'b1);
    walk(4'h3, 4);
    shift(4, IR_BYPASS, got);
    chk(got, IR_CAPTURE);
    walk(4'h3, 4);
    shift(8, 32'ha5, got);
    chk(got, 32'h4a);
    walk(4'h1, 2);
    cfg_host_i.run = 1'b0;
  endtask
  task automatic complete_run();
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    #300000;
    num_errors++;
    complete_run();
  end
  initial begin
    repeat (2) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    t_start();
    t_cs();
    t_user();
    t_fault();
    t_tap();
    complete_run();
  end
endmodule
